// ==== tb/erf_event_readout_fifo_tb.sv ====
`timescale 1ns/10ps
module erf_event_readout_fifo_tb;
  import erf_pkg::*;
  logic clk = 0, arst_n = 0, slow = 0, irq_seen, rsp_ready;
  logic acq_valid = 0, acq_last = 0, acq_ready, req_valid = 0, req_ready;
  logic rsp_valid, rsp_last, rsp_err, irq_req;
  logic [31:0] acq_data = 0, req_addr = {BASE_RESET, 16'h0FFC}, rsp_data, ctrl_word = 0;
  logic [15:0] req_len = 0;
  logic [5:0]  req_am = AM_BLT;
  logic [1:0]  req_width = WIDTH_D32;
  logic [2:0]  req_node = 3'h5;
  logic [7:0]  event_num = 8'h01;
  logic [2:0]  buffers_used;
  int fails = 0, check_count = 0, wr = 0, rd_n = 0, cyc = 0;

  erf_event_readout_fifo #(.DEPTH(16), .NUM_BUF(4)) erf_event_readout_fifo_inst (
    .clk(clk), .arst_n(arst_n), .acq_valid(acq_valid), .acq_data(acq_data),
    .acq_last(acq_last), .acq_ready(acq_ready), .req_valid(req_valid),
    .req_ready(req_ready), .req_node(req_node), .req_am(req_am), .req_addr(req_addr),
    .req_width(req_width), .req_len(req_len), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_last(rsp_last), .rsp_err(rsp_err),
    .rsp_ready(rsp_ready), .event_num(event_num), .ctrl_word(ctrl_word),
    .node_id(3'h5), .base_addr(BASE_RESET), .irq_req(irq_req),
    .buffers_used(buffers_used));

  erf_host_model erf_host_model_inst (
    .clk(clk), .arst_n(arst_n), .slow(slow), .irq_req(irq_req),
    .rsp_ready(rsp_ready), .irq_seen(irq_seen));

  initial begin
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // one event of n words; data counts up so order shows on readout
  task automatic push(input int n);
    for (int i = 0; i < n; i++) begin
      acq_valid = 1'b1;
      acq_data  = 32'h0000_A000 + wr;
      acq_last  = (i == n - 1);
      while (!acq_ready) @(negedge clk);
      @(negedge clk);
      wr++;
    end
    acq_valid = 1'b0;
    // one idle edge so a following push never re-raises valid in the same step
    @(negedge clk);
  endtask

  task automatic rd(input logic [15:0] len, input int exp_n, input logic err);
    int got;
    got = 0;
    req_valid = 1'b1;
    req_len   = len;
    while (!req_ready) @(negedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    forever begin
      @(negedge clk);
      if (rsp_valid && rsp_ready) begin
        got++;
        chk({31'h0, rsp_err}, {31'h0, err});
        if (!err) begin
          chk(rsp_data, 32'h0000_A000 + rd_n);
          rd_n++;
        end
        if (rsp_last) break;
      end
    end
    chk(32'(got), 32'(exp_n));
  endtask

  task automatic t_empty_and_exact();
    rd(16'h0001, 1, 1'b1);
    event_num = 8'h02;
    push(3);
    push(3);
    rd(16'h0006, 6, 1'b0);
    $display("test exact done");
  endtask

  task automatic t_over_short_bad();
    event_num = 8'h01;
    push(3);
    rd(16'h000A, 3, 1'b0);
    push(3);
    rd(16'h0002, 2, 1'b0);
    req_am = 6'h3F;
    rd(16'h0001, 1, 1'b1);
    req_am = AM_BLT;
    rd(16'h0005, 1, 1'b0);
    $display("test over short done");
  endtask

  task automatic t_bad_fields();
    push(1);
    req_width = 2'h1;
    rd(16'h0001, 1, 1'b1);
    req_width = WIDTH_D32;
    req_addr  = {16'h1234, 16'h0000};
    rd(16'h0001, 1, 1'b1);
    req_addr  = {BASE_RESET, 16'h1000};
    rd(16'h0001, 1, 1'b1);
    req_addr  = {BASE_RESET, 16'h0002};
    rd(16'h0001, 1, 1'b1);
    req_addr  = {BASE_RESET, 16'h0000};
    // another chain position: taken, never answered
    req_node  = 3'h2;
    req_valid = 1'b1;
    while (!req_ready) @(negedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    repeat (4) @(negedge clk);
    chk({31'h0, rsp_valid}, 32'h0);
    chk({31'h0, req_ready}, 32'h1);
    req_node  = 3'h5;
    rd(16'h0001, 1, 1'b0);
    $display("test bad fields done");
  endtask

  task automatic t_full_irq();
    for (int e = 0; e < 4; e++) push(2);
    acq_valid = 1'b1;
    acq_last  = 1'b1;
    acq_data  = 32'h0000_A000 + wr;
    repeat (3) @(negedge clk);
    chk(32'(buffers_used), 32'h4);
    chk({31'h0, acq_ready}, 32'h0);
    repeat (3) @(negedge clk);
    chk({31'h0, irq_req}, 32'h0);
    ctrl_word = 32'h0000_0008;
    repeat (3) @(negedge clk);
    chk({31'h0, irq_seen}, 32'h1);
    slow = 1'b1;
    rd(16'h0010, 2, 1'b0);
    // the freed buffer is claimed at once by the waiting single-word event
    repeat (3) @(negedge clk);
    chk(32'(buffers_used), 32'h4);
    chk({31'h0, acq_ready}, 32'h0);
    wr++;
    acq_valid = 1'b0;
    for (int e = 0; e < 3; e++) rd(16'h0002, 2, 1'b0);
    ctrl_word = 32'h0;
    repeat (3) @(negedge clk);
    chk({31'h0, irq_req}, 32'h0);
    rd(16'h0001, 1, 1'b0);
    repeat (2) @(negedge clk);
    chk(32'(buffers_used), 32'h0);
    chk({31'h0, acq_ready}, 32'h1);
    $display("test full irq done");
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      wrap_up();
    end
  end

  initial begin
    repeat (12) @(negedge clk);
    arst_n = 1'b1;
    repeat (2) @(negedge clk);
    t_empty_and_exact();
    t_over_short_bad();
    t_bad_fields();
    t_full_irq();
    wrap_up();
  end
endmodule

// ==== tb/erf_host_model.sv ====
`timescale 1ns/10ps
module erf_host_model (
  input  wire logic clk,       // system clock
  input  wire logic arst_n,    // async reset
  input  wire logic slow,      // stall every other cycle
  input  wire logic irq_req,   // request from the link
  output logic      rsp_ready, // takes answer word
  output logic      irq_seen   // interrupt passed to host bus
);
  logic tog_reg;
  logic tog_next;
  always_comb begin
    tog_next = ~tog_reg;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tog_reg  <= 1'b0;
      irq_seen <= 1'b0;
    end else begin
      tog_reg  <= tog_next;
      irq_seen <= irq_req;
    end
  end
  // a host that stalls is the harder case for the answer buffer
  assign rsp_ready = !slow || tog_reg;
endmodule

// ==== verilog/erf_event_readout_fifo.sv ====
`timescale 1ns/10ps
// Behaviour
// - window range pops next stored word
// - transfers aligned to programmed event count
// - exact N*X request streams without gaps
// - over-long request cut at N*X
// - unknown size: min(request, aligned total)
// - fully read event frees its buffer
// - storage continues during readout
// - storage stalls only when buffers full or word storage full
// - bad AM, base or width: bus error
// - control bit 3 gates interrupt request
// - up to eight devices per chain
module erf_event_readout_fifo
  import erf_pkg::*;
#(
  parameter int DEPTH   = erf_pkg::FIFO_DEPTH,
  parameter int NUM_BUF = erf_pkg::NUM_BUFFERS
) (
  input  wire logic                           clk,          // 125 MHz
  input  wire logic                           arst_n,       // async reset
  input  wire logic                           acq_valid,    // acquisition word valid
  input  wire logic [erf_pkg::DATA_W-1:0]     acq_data,     // acquisition word
  input  wire logic                           acq_last,     // last word of event
  output logic                                acq_ready,    // storage accepts word
  input  wire logic                           req_valid,    // link access request
  output logic                                req_ready,    // request accepted
  input  wire logic [erf_pkg::NODE_W-1:0]     req_node,     // chain position addressed
  input  wire logic [erf_pkg::AM_W-1:0]       req_am,       // address modifier
  input  wire logic [erf_pkg::ADDR_W-1:0]     req_addr,     // base and offset
  input  wire logic [erf_pkg::WID_W-1:0]      req_width,    // data width code
  input  wire logic [erf_pkg::LEN_W-1:0]      req_len,      // words asked
  output logic                                rsp_valid,    // answer word valid
  output logic [erf_pkg::DATA_W-1:0]          rsp_data,     // answer word
  output logic                                rsp_last,     // transfer ends here
  output logic                                rsp_err,      // bus error
  input  wire logic                           rsp_ready,    // host takes word
  input  wire logic [erf_pkg::EVN_W-1:0]      event_num,    // events per transfer
  input  wire logic [erf_pkg::CTRL_W-1:0]     ctrl_word,    // control register
  input  wire logic [erf_pkg::NODE_W-1:0]     node_id,      // own chain position
  input  wire logic [15:0]                    base_addr,    // board base
  output logic                                irq_req,      // interrupt to link
  output logic [$clog2(NUM_BUF+1)-1:0]        buffers_used  // occupied buffers
);
  import erf_pkg::*;

  localparam int PTR_W = $clog2(DEPTH);
  localparam int BUF_W = $clog2(NUM_BUF+1);
  localparam int ENT_W = DATA_W + 2;

  function automatic logic [LEN_W-1:0] min_len(input logic [LEN_W-1:0] a,
                                               input logic [LEN_W-1:0] b);
    return (a < b) ? a : b;
  endfunction

  logic [DATA_W:0]    mem [DEPTH];
  erf_state_e         state_reg, state_next;
  logic [PTR_W-1:0]   wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [PTR_W:0]     wcnt_reg, wcnt_next;
  logic [BUF_W-1:0]   bufs_reg, bufs_next, evd_reg, evd_next;
  logic               in_ev_reg, in_ev_next;
  logic [LEN_W-1:0]   wleft_reg, wleft_next, eleft_reg, eleft_next;
  logic               acq_rdy_reg, acq_rdy_next, req_rdy_reg, req_rdy_next;
  logic               irq_reg, irq_next;
  logic               vh_reg, vh_next, vs_reg, vs_next;
  logic [ENT_W-1:0]   dh_reg, dh_next, ds_reg, ds_next;

  logic               push_acq, take, hit, bad, pop_mem, mem_last, fin, push_out, pop_out;
  logic [ENT_W-1:0]   entry;
  logic [LEN_W-1:0]   n_eff;

  always_comb begin
    push_acq = acq_valid && acq_rdy_reg;
    take     = req_valid && req_rdy_reg;
    hit      = (req_node == node_id);
    bad      = !erf_am_ok(req_am) || (req_width != WIDTH_D32)
               || (req_addr[31:16] != base_addr) || (req_addr[15:0] > WIN_HI)
               || (req_addr[1:0] != 2'h0);
    mem_last = mem[rd_ptr_reg][DATA_W];
    // one word per cycle while the answer buffer has room: no gaps inside a transfer
    pop_mem  = (state_reg == ST_XFER) && !vs_reg && (wcnt_reg != '0);
    fin      = pop_mem && ((wleft_reg == 16'h0001)
               || (mem_last && (eleft_reg == 16'h0001)));
    push_out = pop_mem || ((state_reg == ST_ERR) && !vs_reg);
    entry    = (state_reg == ST_ERR) ? {1'b1, 1'b1, {DATA_W{1'b0}}}
                                     : {1'b0, fin, mem[rd_ptr_reg][DATA_W-1:0]};
    pop_out  = vh_reg && rsp_ready;
    n_eff    = (event_num == '0) ? 16'h0001 : {{(LEN_W-EVN_W){1'b0}}, event_num};

    wr_ptr_next = push_acq ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
    rd_ptr_next = pop_mem ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
    wcnt_next   = wcnt_reg + (PTR_W+1)'(push_acq) - (PTR_W+1)'(pop_mem);
    in_ev_next  = push_acq ? !acq_last : in_ev_reg;
    // a buffer is claimed by the first word and released by the last word read
    bufs_next   = bufs_reg + BUF_W'(push_acq && !in_ev_reg)
                  - BUF_W'(pop_mem && mem_last);
    evd_next    = evd_reg + BUF_W'(push_acq && acq_last) - BUF_W'(pop_mem && mem_last);
    // stall only for no free buffer or no room; a started event always completes
    acq_rdy_next = (wcnt_next < (PTR_W+1)'(DEPTH))
                   && (in_ev_next || (bufs_next < BUF_W'(NUM_BUF)));

    state_next = state_reg;
    wleft_next = wleft_reg;
    eleft_next = eleft_reg;
    case (state_reg)
      ST_IDLE: begin
        if (take && hit) begin
          if (bad || (evd_reg == '0)) begin
            state_next = ST_ERR;
          end else begin
            state_next = ST_XFER;
            wleft_next = (req_len == '0) ? 16'h0001 : req_len;
            eleft_next = min_len(n_eff, {{(LEN_W-BUF_W){1'b0}}, evd_reg});
          end
        end
      end
      ST_XFER: begin
        if (pop_mem) begin
          wleft_next = wleft_reg - 1'b1;
          eleft_next = mem_last ? eleft_reg - 1'b1 : eleft_reg;
        end
        if (fin) begin
          state_next = ST_IDLE;
        end
      end
      ST_ERR: begin
        if (!vs_reg) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
    req_rdy_next = (state_next == ST_IDLE);
    irq_next     = ctrl_word[CTRL_IRQ_EN] && (evd_next != '0);

    // two-entry answer buffer: host stalls never drop a word
    vh_next = vh_reg;
    dh_next = dh_reg;
    vs_next = vs_reg;
    ds_next = ds_reg;
    if (pop_out) begin
      if (vs_reg) begin
        dh_next = ds_reg;
        vs_next = push_out;
        ds_next = entry;
      end else begin
        vh_next = push_out;
        dh_next = entry;
      end
    end else if (push_out) begin
      if (!vh_reg) begin
        vh_next = 1'b1;
        dh_next = entry;
      end else begin
        vs_next = 1'b1;
        ds_next = entry;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg   <= ST_IDLE;
      wr_ptr_reg  <= '0;
      rd_ptr_reg  <= '0;
      wcnt_reg    <= '0;
      bufs_reg    <= '0;
      evd_reg     <= '0;
      in_ev_reg   <= 1'b0;
      wleft_reg   <= '0;
      eleft_reg   <= '0;
      acq_rdy_reg <= 1'b0;
      req_rdy_reg <= 1'b0;
      irq_reg     <= 1'b0;
      vh_reg      <= 1'b0;
      vs_reg      <= 1'b0;
      dh_reg      <= '0;
      ds_reg      <= '0;
    end else begin
      state_reg   <= state_next;
      wr_ptr_reg  <= wr_ptr_next;
      rd_ptr_reg  <= rd_ptr_next;
      wcnt_reg    <= wcnt_next;
      bufs_reg    <= bufs_next;
      evd_reg     <= evd_next;
      in_ev_reg   <= in_ev_next;
      wleft_reg   <= wleft_next;
      eleft_reg   <= eleft_next;
      acq_rdy_reg <= acq_rdy_next;
      req_rdy_reg <= req_rdy_next;
      irq_reg     <= irq_next;
      vh_reg      <= vh_next;
      vs_reg      <= vs_next;
      dh_reg      <= dh_next;
      ds_reg      <= ds_next;
    end
  end

  // storage array has no reset; contents are only read behind the count
  always_ff @(posedge clk) begin
    if (push_acq) begin
      mem[wr_ptr_reg] <= {acq_last, acq_data};
    end
  end

  assign acq_ready    = acq_rdy_reg;
  assign req_ready    = req_rdy_reg;
  assign irq_req      = irq_reg;
  assign buffers_used = bufs_reg;
  assign rsp_valid    = vh_reg;
  assign rsp_err      = dh_reg[ENT_W-1];
  assign rsp_last     = dh_reg[ENT_W-2];
  assign rsp_data     = dh_reg[DATA_W-1:0];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_rd_advance;
    pop_mem |=> (rd_ptr_reg == $past(rd_ptr_reg) + 1'b1);
  endproperty
  a_rd_advance: assert property (p_rd_advance) else $error("read pointer not advanced");

  // leaving a transfer is only legal on the last asked word or the last word of event N, or of the last stored event when fewer than N are stored
  property p_fin_aligned;
    (state_reg != ST_XFER) && $past(state_reg == ST_XFER)
      |-> $past(pop_mem) && (($past(wleft_reg) == 16'h0001)
          || ($past(mem_last) && ($past(eleft_reg) == 16'h0001)));
  endproperty
  a_fin_aligned: assert property (p_fin_aligned) else $error("transfer ended off boundary");

  property p_no_gap;
    (state_reg == ST_XFER) && (wcnt_reg != '0) |=> rsp_valid;
  endproperty
  a_no_gap: assert property (p_no_gap) else $error("gap inside transfer");

  property p_cut;
    fin |=> (state_reg == ST_IDLE) && req_ready;
  endproperty
  a_cut: assert property (p_cut) else $error("transfer not ended by device");

  property p_free;
    pop_mem && mem_last && !(push_acq && !in_ev_reg) |=> bufs_reg == $past(bufs_reg) - 1'b1;
  endproperty
  a_free: assert property (p_free) else $error("buffer not freed");

  property p_store_free;
    !in_ev_reg && (bufs_reg < BUF_W'(NUM_BUF)) && (wcnt_reg < (PTR_W+1)'(DEPTH))
      && $past(arst_n) |-> acq_ready;
  endproperty
  a_store_free: assert property (p_store_free) else $error("storage stalled with room");

  property p_store_full;
    !in_ev_reg && (bufs_reg == BUF_W'(NUM_BUF)) |-> !acq_ready;
  endproperty
  a_store_full: assert property (p_store_full) else $error("storage on full buffers");

  property p_berr;
    take && hit && bad |=> (state_reg == ST_ERR) ##[1:3] (vh_reg && dh_reg[ENT_W-1]);
  endproperty
  a_berr: assert property (p_berr) else $error("bad access not errored");

  property p_irq_gate;
    !ctrl_word[CTRL_IRQ_EN] |=> !irq_req;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt while disabled");

  property p_other_node;
    take && !hit |=> (state_reg == ST_IDLE);
  endproperty
  a_other_node: assert property (p_other_node) else $error("answered other node");

  c_xfer_done: cover property (fin && mem_last);
  c_cut_short: cover property (fin && !mem_last);
  c_berr:      cover property (take && hit && bad);
  c_full:      cover property (!acq_ready && (bufs_reg == BUF_W'(NUM_BUF)));
endmodule

// ==== verilog/erf_pkg.sv ====
package erf_pkg;
  localparam int          DATA_W       = 32;
  localparam int          ADDR_W       = 32;
  localparam int          AM_W         = 6;
  localparam int          WID_W        = 2;
  localparam int          LEN_W        = 16;
  localparam int          EVN_W        = 8;
  localparam int          NODE_W       = 3;            // eight devices on one chain
  localparam int          MAX_CHAIN    = 8;
  localparam int          FIFO_DEPTH   = 1024;
  localparam int          NUM_BUFFERS  = 16;
  // readout window: every aligned offset in this range pops the next word
  localparam logic [15:0] WIN_LO       = 16'h0000;
  localparam logic [15:0] WIN_HI       = 16'h0FFC;
  localparam logic [15:0] BASE_RESET   = 16'h3200;     // arbitrary default board base
  localparam logic [AM_W-1:0] AM_SINGLE     = 6'h09;
  localparam logic [AM_W-1:0] AM_BLT        = 6'h0B;
  localparam logic [AM_W-1:0] AM_SUP_SINGLE = 6'h0D;
  localparam logic [AM_W-1:0] AM_SUP_BLT    = 6'h0F;
  localparam logic [WID_W-1:0] WIDTH_D32    = 2'h2;
  localparam int          CTRL_IRQ_EN  = 3;
  localparam int          CTRL_W       = 32;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_XFER = 3'h2,
    ST_ERR  = 3'h4
  } erf_state_e;

  function automatic logic erf_am_ok(input logic [AM_W-1:0] am);
    return (am == AM_SINGLE) || (am == AM_BLT) || (am == AM_SUP_SINGLE) || (am == AM_SUP_BLT);
  endfunction
endpackage
